// ===== watchdog_aux.sv
// Watchdog timer with auxiliary pin mode routing
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Eight-bit timeout count in whole seconds
// - Fire whenever enabled and count is zero
// - Writing the count reloads and clears firing
// - Firing time is count minus up to one
// - Count resets to zero; enable fires at once
// - Control bit 1 enables watchdog, resets zero
// - Control bit 2 lets firing reset board
// - Control bit 7 gates the watchdog interrupt
// - Bits 6:4 select serialized interrupt number
// - Status bit 0 sticky fired flag
// - Control bit 3 ignores writes, reads zero
// - Platform reset restores control and timeout
// - Mode reset depends on power-save enable
// - Mode bit 3 drives fired indication pin
// - Mode bit 2 passes pin to wake
// - Mode bit 1 passes pin to wireless-disable
// - Mode bit 0 passes pin to sleep
// - Pin levels stay readable in alternate modes
// - Per-pin polarity bit inverts the pin
module watchdog_aux
   import watchdog_aux_pkg::*;
#(
   parameter longint TICK_CYCLES_P = TICK_CYCLES
)(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        power_on_rst_n,
   input  wire logic        power_save_enable,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic [7:0]  aux_pin_in,
   input  wire logic [7:0]  aux_gpio_out,
   input  wire logic [7:0]  aux_gpio_oe,
   output logic      [7:0]  aux_pin_out,
   output logic      [7:0]  aux_pin_oe,
   output logic      [7:0]  aux_pin_level,
   input  wire logic        compare_output_ch3,
   input  wire logic        compare_output_ch4,
   output logic             capture_input_ch3,
   output logic             capture_input_ch4,
   output logic             wake_n,
   output logic             wireless_disable_n,
   output logic             sleep_n,
   output logic             board_reset_req,
   output logic             irq_request,
   output logic      [3:0]  irq_number
);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0]  aux_pin_mode_select;
   logic [7:0]  aux_pin_polarity;
   logic [7:0]  watchdog_timeout_seconds;
   logic        interrupt_gate;
   logic [2:0]  interrupt_number_select;
   logic        reset_on_fire;
   logic        watchdog_run;
   logic        watchdog_fired_flag;
   logic [31:0] tick_count;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire logic wr_mode    = reg_wr && (reg_addr == ADDR_AUX_PIN_MODE_SELECT);
   wire logic wr_ctl     = reg_wr && (reg_addr == ADDR_WATCHDOG_CONTROL_STATUS);
   wire logic wr_timeout = reg_wr && (reg_addr == ADDR_WATCHDOG_TIMEOUT);
   wire logic wr_pol     = reg_wr && (reg_addr == ADDR_AUX_PIN_POLARITY);
   wire logic tick       = (tick_count == 32'(TICK_CYCLES_P - 1));
   wire logic fire_now   = watchdog_run && (watchdog_timeout_seconds == 8'h00);
   wire logic run_next   = wr_ctl ? reg_wdata[CTL_RUN_BIT] : watchdog_run;
   wire logic [7:0] ctl_read = {interrupt_gate, interrupt_number_select, 1'b0,
                                reset_on_fire, watchdog_run, watchdog_fired_flag};
   // Mode register keeps its value across platform reset while power save is on
   wire logic mode_rst   = !power_on_rst_n || (!rst_n && !power_save_enable);

   // ---------------------------------------------------------------
   // One-second prescaler, free running
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n || tick) begin
         tick_count <= 32'h0;
      end else begin
         tick_count <= tick_count + 32'h1;
      end
   end

   // ---------------------------------------------------------------
   // Timeout count
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         watchdog_timeout_seconds <= RST_TIMEOUT;
      end else if (wr_timeout) begin
         watchdog_timeout_seconds <= reg_wdata;
      end else if (tick && watchdog_run && (watchdog_timeout_seconds != 8'h00)) begin
         watchdog_timeout_seconds <= watchdog_timeout_seconds - 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // Control bits
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         interrupt_gate          <= RST_CONTROL[CTL_IRQ_GATE];
         interrupt_number_select <= RST_CONTROL[CTL_SEL_MSB:CTL_SEL_LSB];
         reset_on_fire           <= RST_CONTROL[CTL_RESET_EN];
         watchdog_run            <= RST_CONTROL[CTL_RUN_BIT];
      end else if (wr_ctl) begin
         interrupt_gate          <= reg_wdata[CTL_IRQ_GATE];
         interrupt_number_select <= reg_wdata[CTL_SEL_MSB:CTL_SEL_LSB];
         reset_on_fire           <= reg_wdata[CTL_RESET_EN];
         watchdog_run            <= reg_wdata[CTL_RUN_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Sticky fired flag; a clear in the firing cycle wins
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         watchdog_fired_flag <= RST_CONTROL[CTL_FIRED_BIT];
      end else if (fire_now && run_next && !wr_timeout) begin
         watchdog_fired_flag <= 1'b1;
      end else if (wr_timeout || !run_next) begin
         watchdog_fired_flag <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Auxiliary pin mode and polarity
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (mode_rst) begin
         aux_pin_mode_select <= RST_MODE;
         aux_pin_polarity    <= RST_POLARITY;
      end else begin
         if (wr_mode) begin
            aux_pin_mode_select <= reg_wdata;
         end
         if (wr_pol) begin
            aux_pin_polarity <= reg_wdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   wire logic [7:0] rd_mux = (reg_addr == ADDR_AUX_PIN_MODE_SELECT)     ? aux_pin_mode_select :
                             (reg_addr == ADDR_WATCHDOG_CONTROL_STATUS) ? ctl_read :
                             (reg_addr == ADDR_WATCHDOG_TIMEOUT)        ? watchdog_timeout_seconds :
                             (reg_addr == ADDR_AUX_PIN_POLARITY)        ? aux_pin_polarity :
                             (reg_addr == ADDR_AUX_PIN_LEVEL)           ? aux_pin_level :
                             8'h00;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt and board reset
   // ---------------------------------------------------------------
   logic [3:0] irq_map;
   always_comb begin
      unique case (interrupt_number_select)
         3'h0: irq_map = 4'h3;
         3'h1: irq_map = 4'h4;
         3'h2: irq_map = 4'h5;
         3'h3: irq_map = 4'hA;
         3'h4: irq_map = 4'h6;
         3'h5: irq_map = 4'h7;
         3'h6: irq_map = 4'h9;
         3'h7: irq_map = 4'hB;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         irq_request     <= 1'b0;
         irq_number      <= 4'h3;
         board_reset_req <= 1'b0;
      end else begin
         irq_request     <= watchdog_fired_flag && interrupt_gate;
         irq_number      <= irq_map;
         board_reset_req <= watchdog_fired_flag && reset_on_fire;
      end
   end

   // ---------------------------------------------------------------
   // Pin routing; polarity applies in both directions
   // ---------------------------------------------------------------
   wire logic [7:0] pin_logic = aux_pin_in ^ aux_pin_polarity;
   wire logic [7:0] m = aux_pin_mode_select;
   logic [7:0] drive_val;
   logic [7:0] drive_oe;

   always_comb begin
      drive_val = aux_gpio_out;
      drive_oe  = aux_gpio_oe;
      drive_oe[MODE_PIN8_CAP3] = m[MODE_PIN8_CAP3] ? 1'b0 : aux_gpio_oe[MODE_PIN8_CAP3];
      drive_oe[MODE_PIN7_CAP4] = m[MODE_PIN7_CAP4] ? 1'b0 : aux_gpio_oe[MODE_PIN7_CAP4];
      if (m[MODE_PIN6_CMP3]) begin
         drive_val[MODE_PIN6_CMP3] = compare_output_ch3;
         drive_oe[MODE_PIN6_CMP3]  = 1'b1;
      end
      if (m[MODE_PIN5_CMP4]) begin
         drive_val[MODE_PIN5_CMP4] = compare_output_ch4;
         drive_oe[MODE_PIN5_CMP4]  = 1'b1;
      end
      if (m[MODE_PIN4_WDOG]) begin
         drive_val[MODE_PIN4_WDOG] = watchdog_fired_flag;
         drive_oe[MODE_PIN4_WDOG]  = 1'b1;
      end
      drive_oe[MODE_PIN3_WAKE]  = m[MODE_PIN3_WAKE]  ? 1'b0 : aux_gpio_oe[MODE_PIN3_WAKE];
      drive_oe[MODE_PIN2_WDIS]  = m[MODE_PIN2_WDIS]  ? 1'b0 : aux_gpio_oe[MODE_PIN2_WDIS];
      drive_oe[MODE_PIN1_SLEEP] = m[MODE_PIN1_SLEEP] ? 1'b0 : aux_gpio_oe[MODE_PIN1_SLEEP];
   end

   // Fired level 1 becomes the low pin of mode bit 3 unless the pin is inverted; other pins drive level 1 high unless inverted
   always_ff @(posedge ref_clk) begin
      if (mode_rst) begin
         aux_pin_out        <= 8'h00;
         aux_pin_oe         <= 8'h00;
         capture_input_ch3  <= 1'b0;
         capture_input_ch4  <= 1'b0;
         wake_n             <= 1'b1;
         wireless_disable_n <= 1'b1;
         sleep_n            <= 1'b1;
         aux_pin_level      <= 8'h00;
      end else begin
         aux_pin_out        <= drive_val ^ aux_pin_polarity ^
                               (m[MODE_PIN4_WDOG] ? 8'h08 : 8'h00);
         aux_pin_oe         <= drive_oe;
         capture_input_ch3  <= m[MODE_PIN8_CAP3] & pin_logic[MODE_PIN8_CAP3];
         capture_input_ch4  <= m[MODE_PIN7_CAP4] & pin_logic[MODE_PIN7_CAP4];
         wake_n             <= !(m[MODE_PIN3_WAKE] & !pin_logic[MODE_PIN3_WAKE]);
         wireless_disable_n <= !(m[MODE_PIN2_WDIS] & !pin_logic[MODE_PIN2_WDIS]);
         sleep_n            <= !(m[MODE_PIN1_SLEEP] & !pin_logic[MODE_PIN1_SLEEP]);
         aux_pin_level      <= pin_logic;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_FIRE_SETS_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n)
      fire_now && !wr_ctl && !wr_timeout |=> watchdog_fired_flag)
      else $error("fired flag not set on zero count");
   AST_WRITE_RELOADS: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_timeout |=> watchdog_timeout_seconds == $past(reg_wdata) && !watchdog_fired_flag)
      else $error("timeout write did not reload");
   AST_DISABLE_CLEARS: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_ctl && !reg_wdata[CTL_RUN_BIT] |=> !watchdog_fired_flag && !watchdog_run)
      else $error("disable did not clear flag");
   AST_TICK_DECREMENTS: assert property (@(posedge ref_clk) disable iff (!rst_n)
      tick && watchdog_run && watchdog_timeout_seconds != 8'h00 && !wr_timeout
      |=> watchdog_timeout_seconds == $past(watchdog_timeout_seconds) - 8'h01)
      else $error("count did not decrement on tick");
   AST_HOLD_NO_TICK: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !tick && !wr_timeout |=> $stable(watchdog_timeout_seconds))
      else $error("count moved without a tick");
   AST_BOARD_RESET: assert property (@(posedge ref_clk) disable iff (!rst_n)
      watchdog_fired_flag && reset_on_fire ##1 1'b1 |-> board_reset_req || !$past(rst_n))
      else $error("board reset missing");
   AST_IRQ_GATED: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !interrupt_gate ##1 !$past(wr_ctl) |-> !irq_request)
      else $error("interrupt while gated");
   AST_RSVD_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
      reg_rd && reg_addr == ADDR_WATCHDOG_CONTROL_STATUS |=> !reg_rdata[CTL_RSVD_BIT])
      else $error("reserved bit read as one");
   AST_WDOG_PIN: assert property (@(posedge ref_clk) disable iff (!rst_n)
      m[MODE_PIN4_WDOG] && $stable(m) |=> aux_pin_oe[MODE_PIN4_WDOG])
      else $error("fired pin not driven");

endmodule : watchdog_aux

`default_nettype wire

// ===== watchdog_aux_pkg.sv
// Package: register indices, field positions, reset values and timing for the watchdog block
package watchdog_aux_pkg;

   // ---------------------------------------------------------------
   // Register map (index on the plain register port)
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_AUX_PIN_MODE_SELECT     = 4'h0;
   localparam logic [3:0] ADDR_WATCHDOG_CONTROL_STATUS = 4'h1;
   localparam logic [3:0] ADDR_WATCHDOG_TIMEOUT        = 4'h2;
   localparam logic [3:0] ADDR_AUX_PIN_POLARITY        = 4'h3;
   localparam logic [3:0] ADDR_AUX_PIN_LEVEL           = 4'h4;

   // ---------------------------------------------------------------
   // Control/status field positions
   // ---------------------------------------------------------------
   localparam int CTL_FIRED_BIT   = 0;
   localparam int CTL_RUN_BIT     = 1;
   localparam int CTL_RESET_EN    = 2;
   localparam int CTL_RSVD_BIT    = 3;
   localparam int CTL_SEL_LSB     = 4;
   localparam int CTL_SEL_MSB     = 6;
   localparam int CTL_IRQ_GATE    = 7;

   // ---------------------------------------------------------------
   // Mode field positions
   // ---------------------------------------------------------------
   localparam int MODE_PIN1_SLEEP   = 0;
   localparam int MODE_PIN2_WDIS    = 1;
   localparam int MODE_PIN3_WAKE    = 2;
   localparam int MODE_PIN4_WDOG    = 3;
   localparam int MODE_PIN5_CMP4    = 4;
   localparam int MODE_PIN6_CMP3    = 5;
   localparam int MODE_PIN7_CAP4    = 6;
   localparam int MODE_PIN8_CAP3    = 7;

   // ---------------------------------------------------------------
   // Reset values and control write mask
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_MODE     = 8'h00;
   localparam logic [7:0] RST_CONTROL  = 8'h00;
   localparam logic [7:0] RST_TIMEOUT  = 8'h00;
   localparam logic [7:0] RST_POLARITY = 8'h00;
   localparam logic [7:0] CTL_WR_MASK  = 8'hF6;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam longint CLK_HZ        = 100000000;
   localparam longint TICK_PERIOD_S = 1;
   localparam longint TICK_CYCLES   = CLK_HZ * TICK_PERIOD_S;

endpackage : watchdog_aux_pkg

// ===== host_model.sv
// Host-side register master model that drives the watchdog block's register port
`timescale 1ns/100ps
`default_nettype none
module host_model
   import watchdog_aux_pkg::*;
(
   input  wire logic       ref_clk,
   output logic      [3:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr  = 4'h0;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // ------------------------------------------------
   // Bus cycles
   // ------------------------------------------------
   task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
      // Idle data never keeps the last value
      reg_wdata <= ~d;
   endtask : write_reg

   task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : read_reg

   // ------------------------------------------------
   // Watchdog servicing
   // ------------------------------------------------
   task automatic arm(input logic [7:0] secs, input logic [7:0] ctl);
      write_reg(ADDR_WATCHDOG_TIMEOUT, secs);
      write_reg(ADDR_WATCHDOG_CONTROL_STATUS, ctl);
   endtask : arm

   task automatic service(input logic [7:0] secs);
      write_reg(ADDR_WATCHDOG_TIMEOUT, secs);
   endtask : service
endmodule : host_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking testbench for the watchdog block with auxiliary pin modes
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin mismatches++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module tb_top
   import watchdog_aux_pkg::*;
;
   logic       ref_clk, rst_n, power_on_rst_n, power_save_enable;
   logic [3:0] reg_addr, irq_number;
   logic [7:0] reg_wdata, reg_rdata, aux_pin_in, aux_gpio_out, aux_gpio_oe;
   logic [7:0] aux_pin_out, aux_pin_oe, aux_pin_level;
   logic       reg_wr, reg_rd, compare_output_ch3, compare_output_ch4;
   logic       capture_input_ch3, capture_input_ch4, wake_n, wireless_disable_n, sleep_n;
   logic       board_reset_req, irq_request;
   int         mismatches, checks_done;
   logic [7:0] d;

   watchdog_aux #(.TICK_CYCLES_P(20)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .power_on_rst_n(power_on_rst_n), .power_save_enable(power_save_enable),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .aux_pin_in(aux_pin_in), .aux_gpio_out(aux_gpio_out),
      .aux_gpio_oe(aux_gpio_oe), .aux_pin_out(aux_pin_out), .aux_pin_oe(aux_pin_oe),
      .aux_pin_level(aux_pin_level), .compare_output_ch3(compare_output_ch3),
      .compare_output_ch4(compare_output_ch4), .capture_input_ch3(capture_input_ch3),
      .capture_input_ch4(capture_input_ch4), .wake_n(wake_n),
      .wireless_disable_n(wireless_disable_n), .sleep_n(sleep_n),
      .board_reset_req(board_reset_req), .irq_request(irq_request), .irq_number(irq_number));

   host_model u_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   // ------------------------------------------------
   // Clock, closing and hang guard
   // ------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic finish_test();
      if (mismatches == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test

   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      finish_test();
   end

   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic pulse_reset(input logic pse, input logic por_n);
      @(posedge ref_clk);
      power_save_enable <= pse;
      rst_n             <= 1'b0;
      power_on_rst_n    <= por_n;
      repeat (2) @(posedge ref_clk);
      rst_n          <= 1'b1;
      power_on_rst_n <= 1'b1;
   endtask : pulse_reset

   task automatic reset_values();
      for (int a = 0; a < 4; a++) begin
         u_host.read_reg(4'(a), d);
         `CHK("reset_reg", 8'h00, d)
      end
      u_host.read_reg(4'hF, d);
      `CHK("unmapped", 8'h00, d)
      `CHK("irq_num_rst", 4'h3, irq_number)
      `CHK("gpio_drive", 8'h3C, aux_pin_out)
      `CHK("gpio_oe", 8'hC3, aux_pin_oe)
      `CHK("pass_idle", 3'b111, {wake_n, wireless_disable_n, sleep_n})
   endtask : reset_values

   task automatic pin_case(input logic [7:0] pol, input logic [7:0] pin, input logic c3);
      logic [7:0] lvl;
      lvl = pin ^ pol;
      u_host.write_reg(ADDR_AUX_PIN_POLARITY, pol);
      @(posedge ref_clk);
      aux_pin_in         <= pin;
      compare_output_ch3 <= c3;
      compare_output_ch4 <= ~c3;
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK("pin_level", lvl, aux_pin_level)
      `CHK("capture", lvl[7:6], {capture_input_ch3, capture_input_ch4})
      `CHK("pass_n", lvl[2:0], {wake_n, wireless_disable_n, sleep_n})
      `CHK("cmp_out", {c3 ^ pol[5], ~c3 ^ pol[4]}, aux_pin_out[5:4])
      `CHK("wdog_pin_idle", ~pol[3], aux_pin_out[3])
      `CHK("alt_oe", 8'h38, aux_pin_oe)
      u_host.read_reg(ADDR_AUX_PIN_LEVEL, d);
      `CHK("level_reg", lvl, d)
   endtask : pin_case

   task automatic fire_at_zero();
      u_host.write_reg(ADDR_WATCHDOG_CONTROL_STATUS, 8'hFF);
      u_host.read_reg(ADDR_WATCHDOG_CONTROL_STATUS, d);
      `CHK("ctl_fired", 8'hF7, d)
      `CHK("irq_on", 1'b1, irq_request)
      `CHK("brd_rst_on", 1'b1, board_reset_req)
      `CHK("irq_num11", 4'hB, irq_number)
      `CHK("wdog_pin_fired", 1'b0, aux_pin_out[3])
      u_host.service(8'h05);
      u_host.read_reg(ADDR_WATCHDOG_CONTROL_STATUS, d);
      `CHK("ctl_cleared", 8'hF6, d)
      `CHK("irq_off", 1'b0, irq_request)
      u_host.write_reg(ADDR_WATCHDOG_TIMEOUT, 8'h00);
      u_host.write_reg(ADDR_WATCHDOG_CONTROL_STATUS, 8'h02);
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK("gated_irq", 2'b00, {irq_request, board_reset_req})
      u_host.write_reg(ADDR_WATCHDOG_CONTROL_STATUS, 8'h00);
      u_host.read_reg(ADDR_WATCHDOG_CONTROL_STATUS, d);
      `CHK("run_clear", 8'h00, d)
   endtask : fire_at_zero

   task automatic irq_select();
      logic [3:0] tbl [8];
      tbl = '{4'h3, 4'h4, 4'h5, 4'hA, 4'h6, 4'h7, 4'h9, 4'hB};
      for (int s = 0; s < 8; s++) begin
         u_host.write_reg(ADDR_WATCHDOG_CONTROL_STATUS, {1'b0, 3'(s), 4'h0});
         u_host.read_reg(ADDR_WATCHDOG_CONTROL_STATUS, d);
         `CHK("sel_rb", {1'b0, 3'(s), 4'h0}, d)
         `CHK("irq_num", tbl[s], irq_number)
      end
   endtask : irq_select

   task automatic timed_expiry();
      int n;
      u_host.arm(8'h03, 8'h86);
      for (int i = 0; i < 5; i++) begin
         repeat (30) @(posedge ref_clk);
         u_host.service(8'h03);
         #1;
         `CHK("serviced", 1'b0, irq_request)
      end
      n = 0;
      while (irq_request !== 1'b1 && n < 200) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      `CHK("expiry_window", 1'b1, n >= 39 && n <= 63)
      `CHK("brd_rst_req", 1'b1, board_reset_req)
      u_host.read_reg(ADDR_WATCHDOG_TIMEOUT, d);
      `CHK("count_zero", 8'h00, d)
   endtask : timed_expiry

   task automatic mode_reset();
      u_host.write_reg(ADDR_AUX_PIN_MODE_SELECT, 8'hFF);
      pulse_reset(1'b1, 1'b1);
      u_host.read_reg(ADDR_AUX_PIN_MODE_SELECT, d);
      `CHK("mode_kept", 8'hFF, d)
      u_host.read_reg(ADDR_WATCHDOG_CONTROL_STATUS, d);
      `CHK("ctl_platform", 8'h00, d)
      pulse_reset(1'b1, 1'b0);
      u_host.read_reg(ADDR_AUX_PIN_MODE_SELECT, d);
      `CHK("mode_por", 8'h00, d)
      u_host.write_reg(ADDR_AUX_PIN_MODE_SELECT, 8'hFF);
      pulse_reset(1'b0, 1'b1);
      u_host.read_reg(ADDR_AUX_PIN_MODE_SELECT, d);
      `CHK("mode_platform", 8'h00, d)
   endtask : mode_reset

   initial begin
      mismatches         = 0;
      checks_done        = 0;
      rst_n              = 1'b0;
      power_on_rst_n     = 1'b0;
      power_save_enable  = 1'b0;
      aux_pin_in         = 8'h00;
      aux_gpio_out       = 8'h3C;
      aux_gpio_oe        = 8'hC3;
      compare_output_ch3 = 1'b0;
      compare_output_ch4 = 1'b0;
      repeat (20) @(posedge ref_clk);
      rst_n          <= 1'b1;
      power_on_rst_n <= 1'b1;
      reset_values();
      u_host.write_reg(ADDR_AUX_PIN_MODE_SELECT, 8'hFF);
      pin_case(8'h00, 8'hA5, 1'b1);
      pin_case(8'hFF, 8'h5A, 1'b0);
      u_host.write_reg(ADDR_AUX_PIN_POLARITY, 8'h00);
      fire_at_zero();
      irq_select();
      timed_expiry();
      mode_reset();
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
